// ---- rtl/mfps_top.sv ----
// Function selector for five shared bidirectional pins
`timescale 1ns/1ps
`default_nettype none
module mfps_top (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Pins: input, output, output enable (low = driving)
    input wire logic [4:0] shared_io_in,
    output logic [4:0] shared_io_out,
    output logic [4:0] shared_io_oe_n,
    // Host configuration
    input wire logic [9:0] fn_sel,
    input wire logic [4:0] gp_dir_out,
    input wire logic [4:0] gp_output_data_reg,
    input wire mfps_pkg::mfps_xmode_t ext_mode,
    input wire logic hand_pulse_generator_mode,
    input wire logic sync_pulse_sel,
    input wire logic sync_pulse_act_low,
    input wire logic [7:0] sync_pulse_width,
    // Internal sources
    input wire mfps_pkg::mfps_prof_t prof,
    input wire logic compare_hit_0,
    input wire logic compare_hit_1,
    input wire logic error_active,
    input wire logic sync_pulse_req,
    // Status and requests
    output logic [4:0] gp_input_status_reg,
    output logic [4:0] sync_trigger,
    output mfps_pkg::mfps_drv_t drv_req
);
    logic [4:0] pin_s;
    logic [4:0] pin_d_r;
    logic [4:0] out_nxt;
    logic [4:0] oe_n_nxt;
    logic [1:0] fn [5];
    logic [7:0] sp_cnt_r;
    logic sp_act;
    mfps_pkg::mfps_prof_t pf;

    // Pin input synchroniser
    // Pins are asynchronous, two flops before any logic
    mfps_sync #(.W(5)) u_sync (
        .sys_clk(sys_clk),
        .rst(rst),
        .d(shared_io_in),
        .q(pin_s)
    );

    // Per-pin function field decode
    // Two bits per pin, pin i at bits 2i+1 and 2i
    always_comb begin
        for (int i = 0; i < mfps_pkg::NPINS; i++) begin
            fn[i] = fn_sel[2*i +: 2];
        end
    end

    // Profile flags gated by busy
    // Flags mean nothing outside a running drive
    always_comb begin
        pf = prof;
        pf.accel_rising = prof.busy & prof.accel_rising;
        pf.decel = prof.busy & prof.decel;
        pf.const_spd = prof.busy & prof.const_spd;
        pf.accel = prof.busy & prof.accel;
    end

    // Sync pulse stretcher with programmable width
    // A new request restarts the count, width zero acts as one
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            sp_cnt_r <= 8'h00;
        end else if (sync_pulse_req) begin
            sp_cnt_r <= (sync_pulse_width == 8'h00) ? mfps_pkg::SPW_ONE
                        : sync_pulse_width;
        end else if (sp_cnt_r != 8'h00) begin
            sp_cnt_r <= sp_cnt_r - 8'h01;
        end
    end
    assign sp_act = (sp_cnt_r != 8'h00);

    // Output mux, one function per pin
    // Compare outputs exist only on the two upper pins
    always_comb begin
        out_nxt = 5'h00;
        oe_n_nxt = 5'h1f;
        for (int i = 0; i < mfps_pkg::NPINS; i++) begin
            case (fn[i])
                mfps_pkg::FN_GPIO: begin
                    out_nxt[i] = gp_output_data_reg[i];
                    oe_n_nxt[i] = ~gp_dir_out[i];
                end
                mfps_pkg::FN_STAT: begin
                    oe_n_nxt[i] = 1'b0;
                end
                mfps_pkg::FN_CMP: begin
                    oe_n_nxt[i] = 1'b0;
                end
                default: begin
                    oe_n_nxt[i] = 1'b1;
                end
            endcase
        end
        // Status sources per pin
        if (fn[mfps_pkg::PIN_IO1] == mfps_pkg::FN_STAT) begin
            out_nxt[mfps_pkg::PIN_IO1] = error_active;
        end
        if (fn[mfps_pkg::PIN_IO2] == mfps_pkg::FN_STAT) begin
            out_nxt[mfps_pkg::PIN_IO2] = pf.accel;
        end
        if (fn[mfps_pkg::PIN_IO3] == mfps_pkg::FN_STAT) begin
            if (sync_pulse_sel) begin
                out_nxt[mfps_pkg::PIN_IO3] = sp_act ^ sync_pulse_act_low;
            end else begin
                out_nxt[mfps_pkg::PIN_IO3] = pf.const_spd;
            end
        end
        if (fn[mfps_pkg::PIN_IO4] == mfps_pkg::FN_STAT) begin
            out_nxt[mfps_pkg::PIN_IO4] = pf.decel;
        end
        if (fn[mfps_pkg::PIN_IO4] == mfps_pkg::FN_CMP) begin
            out_nxt[mfps_pkg::PIN_IO4] = compare_hit_0;
        end
        if (fn[mfps_pkg::PIN_IO5] == mfps_pkg::FN_STAT) begin
            out_nxt[mfps_pkg::PIN_IO5] = pf.accel_rising;
        end
        if (fn[mfps_pkg::PIN_IO5] == mfps_pkg::FN_CMP) begin
            out_nxt[mfps_pkg::PIN_IO5] = compare_hit_1;
        end
        // Pins without a compare function stay released
        for (int j = 0; j < 3; j++) begin
            if (fn[j] == mfps_pkg::FN_CMP) begin
                oe_n_nxt[j] = 1'b1;
            end
        end
    end

    // Registered pin drive
    // Registered so a function change never glitches a pin
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            shared_io_out <= 5'h00;
            shared_io_oe_n <= 5'h1f;
        end else begin
            shared_io_out <= out_nxt;
            shared_io_oe_n <= oe_n_nxt;
        end
    end

    // General input status and sync triggers
    // Readback reads zero while the pin serves another function
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            gp_input_status_reg <= 5'h00;
            sync_trigger <= 5'h00;
            pin_d_r <= 5'h1f;
        end else begin
            pin_d_r <= pin_s;
            for (int i = 0; i < mfps_pkg::NPINS; i++) begin
                gp_input_status_reg[i] <= pin_s[i] & (fn[i] == mfps_pkg::FN_GPIO);
                sync_trigger[i] <= pin_s[i] & (fn[i] == mfps_pkg::FN_GPIO);
            end
        end
    end

    // External start and hand encoder decode
    // Hand mode wins whatever the pin functions say
    // Relative moves fire on a high-to-low step of the synced level
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            drv_req <= '0;
        end else begin
            drv_req <= '0;
            if (hand_pulse_generator_mode) begin
                drv_req.hand_a <= pin_s[mfps_pkg::PIN_IO4];
                drv_req.hand_b <= pin_s[mfps_pkg::PIN_IO5];
            end else begin
                if (fn[mfps_pkg::PIN_IO5] == mfps_pkg::FN_EXT) begin
                    if (ext_mode == mfps_pkg::MFPS_XM_POS) begin
                        drv_req.pos_rel_neg <= pin_d_r[mfps_pkg::PIN_IO5]
                                               & ~pin_s[mfps_pkg::PIN_IO5];
                    end
                    if (ext_mode == mfps_pkg::MFPS_XM_CONT) begin
                        drv_req.cont_neg <= ~pin_s[mfps_pkg::PIN_IO5];
                    end
                end
                if (fn[mfps_pkg::PIN_IO4] == mfps_pkg::FN_EXT) begin
                    if (ext_mode == mfps_pkg::MFPS_XM_POS) begin
                        drv_req.pos_rel_pos <= pin_d_r[mfps_pkg::PIN_IO4]
                                               & ~pin_s[mfps_pkg::PIN_IO4];
                    end
                    if (ext_mode == mfps_pkg::MFPS_XM_CONT) begin
                        drv_req.cont_pos <= ~pin_s[mfps_pkg::PIN_IO4];
                    end
                end
            end
        end
    end

    // Checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    // Profile, compare and error pins one cycle behind their source
    stat_idle_low_a: assert property ((!$past(prof.busy) && fn[1] == mfps_pkg::FN_STAT
        && $past(fn[1]) == mfps_pkg::FN_STAT) |-> !shared_io_out[1])
        else $error("accel pin high while idle");
    decel_follow_a: assert property ((fn[3] == mfps_pkg::FN_STAT) |=>
        (shared_io_out[3] == $past(prof.busy & prof.decel)))
        else $error("decel pin mismatch");
    rise_follow_a: assert property ((fn[4] == mfps_pkg::FN_STAT) |=>
        (shared_io_out[4] == $past(prof.busy & prof.accel_rising)))
        else $error("accel rising pin mismatch");
    cmp_zero_a: assert property ((fn[3] == mfps_pkg::FN_CMP) |=>
        (shared_io_out[3] == $past(compare_hit_0) && !shared_io_oe_n[3]))
        else $error("compare 0 pin mismatch");
    cmp_one_a: assert property ((fn[4] == mfps_pkg::FN_CMP) |=>
        (shared_io_out[4] == $past(compare_hit_1)))
        else $error("compare 1 pin mismatch");
    err_follow_a: assert property ((fn[0] == mfps_pkg::FN_STAT) |=>
        (shared_io_out[0] == $past(error_active)))
        else $error("error pin mismatch");
    // Pin direction for input and general purpose functions
    ext_release_a: assert property ((fn[3] == mfps_pkg::FN_EXT) |=> shared_io_oe_n[3])
        else $error("input pin driven");
    gp_out_a: assert property ((fn[2] == mfps_pkg::FN_GPIO && gp_dir_out[2]) |=>
        (shared_io_out[2] == $past(gp_output_data_reg[2]) && !shared_io_oe_n[2]))
        else $error("gp output mismatch");
    // Start requests from synced pin levels
    pos_edge_a: assert property ((!hand_pulse_generator_mode && !rst
        && fn[3] == mfps_pkg::FN_EXT && ext_mode == mfps_pkg::MFPS_XM_POS
        && pin_d_r[3] && !pin_s[3]) |=> drv_req.pos_rel_pos)
        else $error("positive start missed");
    cont_neg_a: assert property ((!hand_pulse_generator_mode
        && fn[4] == mfps_pkg::FN_EXT && ext_mode == mfps_pkg::MFPS_XM_CONT)
        |=> (drv_req.cont_neg == !$past(pin_s[4])))
        else $error("negative continuous mismatch");

    // Remaining drive phase pins follow the gated profile
    accel_follow_a: assert property ((fn[1] == mfps_pkg::FN_STAT) |=>
        (shared_io_out[1] == $past(prof.busy & prof.accel)))
        else $error("accel pin mismatch");
    const_follow_a: assert property ((fn[2] == mfps_pkg::FN_STAT
        && !sync_pulse_sel) |=> (shared_io_out[2] == $past(prof.busy & prof.const_spd)))
        else $error("constant speed pin mismatch");

    // Drive phase pins stay low without a running drive
    const_idle_a: assert property ((!prof.busy && !sync_pulse_sel
        && fn[2] == mfps_pkg::FN_STAT) |=> !shared_io_out[2])
        else $error("constant speed pin high while idle");
    decel_idle_a: assert property ((!prof.busy && fn[3] == mfps_pkg::FN_STAT) |=>
        !shared_io_out[3])
        else $error("decel pin high while idle");
    rise_idle_a: assert property ((!prof.busy && fn[4] == mfps_pkg::FN_STAT) |=>
        !shared_io_out[4])
        else $error("accel rising pin high while idle");

    // Sync pulse pin, counter load and countdown
    sync_pin_a: assert property ((fn[2] == mfps_pkg::FN_STAT && sync_pulse_sel) |=>
        (shared_io_out[2] == ($past(sp_act) ^ $past(sync_pulse_act_low))))
        else $error("sync pulse pin mismatch");
    pulse_load_a: assert property (sync_pulse_req |=>
        (sp_cnt_r == (($past(sync_pulse_width) == 8'h00) ? mfps_pkg::SPW_ONE
        : $past(sync_pulse_width))))
        else $error("sync pulse width not loaded");
    pulse_count_a: assert property ((!sync_pulse_req && sp_act) |=>
        (sp_cnt_r == $past(sp_cnt_r) - 8'h01))
        else $error("sync pulse count stalled");

    // Refused and input functions leave the pin released
    cmp_refuse_a: assert property ((fn[0] == mfps_pkg::FN_CMP) |=>
        (shared_io_oe_n[0] && !shared_io_out[0]))
        else $error("refused compare pin driven");
    neg_release_a: assert property ((fn[4] == mfps_pkg::FN_EXT) |=>
        shared_io_oe_n[4])
        else $error("negative start pin driven");
    gp_in_release_a: assert property ((fn[1] == mfps_pkg::FN_GPIO
        && !gp_dir_out[1]) |=> shared_io_oe_n[1])
        else $error("gp input pin driven");

    // Input status and trigger readback
    gp_status_a: assert property ((fn[2] == mfps_pkg::FN_GPIO) |=>
        (gp_input_status_reg[2] == $past(pin_s[2])))
        else $error("input status mismatch");
    gp_mask_a: assert property ((fn[2] != mfps_pkg::FN_GPIO) |=>
        !gp_input_status_reg[2])
        else $error("input status not masked");
    trig_follow_a: assert property ((fn[0] == mfps_pkg::FN_GPIO) |=>
        (sync_trigger[0] == $past(pin_s[0])))
        else $error("sync trigger mismatch");

    // Start requests and hand encoder routing
    neg_edge_a: assert property ((!hand_pulse_generator_mode
        && fn[4] == mfps_pkg::FN_EXT && ext_mode == mfps_pkg::MFPS_XM_POS
        && pin_d_r[4] && !pin_s[4]) |=> drv_req.pos_rel_neg)
        else $error("negative start missed");
    pos_cause_a: assert property (drv_req.pos_rel_pos |->
        ($past(pin_d_r[3]) && !$past(pin_s[3])))
        else $error("positive start without falling edge");
    cont_pos_a: assert property ((!hand_pulse_generator_mode
        && fn[3] == mfps_pkg::FN_EXT && ext_mode == mfps_pkg::MFPS_XM_CONT)
        |=> (drv_req.cont_pos == !$past(pin_s[3])))
        else $error("positive continuous mismatch");
    phase_a_a: assert property (hand_pulse_generator_mode |=>
        (drv_req.hand_a == $past(pin_s[3])))
        else $error("hand phase A mismatch");
    phase_b_a: assert property (hand_pulse_generator_mode |=>
        (drv_req.hand_b == $past(pin_s[4])))
        else $error("hand phase B mismatch");
    hand_only_a: assert property (hand_pulse_generator_mode |=>
        !(drv_req.pos_rel_pos || drv_req.pos_rel_neg || drv_req.cont_pos || drv_req.cont_neg))
        else $error("start request in hand mode");
    ext_off_a: assert property ((ext_mode == mfps_pkg::MFPS_XM_OFF) |=>
        !(drv_req.pos_rel_pos || drv_req.cont_pos))
        else $error("start request with external drive off");

    // Main scenarios
    sync_pulse_c: cover property (sync_pulse_req ##1 sp_act [*3] ##1 !sp_act);
    pos_start_c: cover property (drv_req.pos_rel_pos);
    neg_cont_c: cover property (drv_req.cont_neg [*3]);
    hand_c: cover property (drv_req.hand_a ##1 drv_req.hand_b);
endmodule
`default_nettype wire

// ---- rtl/mfps_pkg.sv ----
// Package for the shared I/O pin function selector
package mfps_pkg;
    // Pin count and indices (0 = shared_io_1 .. 4 = shared_io_5)
    localparam int NPINS = 5;
    localparam int PIN_IO1 = 0;
    localparam int PIN_IO2 = 1;
    localparam int PIN_IO3 = 2;
    localparam int PIN_IO4 = 3;
    localparam int PIN_IO5 = 4;
    // Per-pin function codes
    localparam logic [1:0] FN_GPIO = 2'h0;
    localparam logic [1:0] FN_EXT = 2'h1;
    localparam logic [1:0] FN_STAT = 2'h2;
    localparam logic [1:0] FN_CMP = 2'h3;
    // Reset values
    localparam logic [9:0] FN_SEL_RST = 10'h000;
    localparam logic [4:0] GP_OUT_RST = 5'h00;
    localparam logic [4:0] GP_DIR_RST = 5'h00;
    // Sync pulse width counter width
    localparam int SPW_W = 8;
    localparam logic [7:0] SPW_ONE = 8'h01;
    // External drive modes
    typedef enum logic [2:0] {
        MFPS_XM_OFF = 3'h1,
        MFPS_XM_POS = 3'h2,
        MFPS_XM_CONT = 3'h4
    } mfps_xmode_t;
    // Drive profile status from motion generator
    typedef struct packed {
        logic busy;
        logic accel_rising;
        logic decel;
        logic const_spd;
        logic accel;
    } mfps_prof_t;
    // Drive start requests toward motion generator
    typedef struct packed {
        logic pos_rel_pos;
        logic pos_rel_neg;
        logic cont_pos;
        logic cont_neg;
        logic hand_a;
        logic hand_b;
    } mfps_drv_t;
endpackage

// ---- rtl/mfps_sync.sv ----
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module mfps_sync #(
    parameter int W = 5
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Data
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_r;

    // Two stages, only second stage read outside
    // Reset to idle high so active-low starts see no false edge
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            meta_r <= '1;
            q <= '1;
        end else begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule
`default_nettype wire

// ---- testbench/mfps_pin_model.sv ----
// Far-side model: switches and hand encoder on the shared pins
`timescale 1ns/1ps
`default_nettype none
module mfps_pin_model (
    // Clock
    input wire logic sys_clk,
    // Device side of the pins
    input wire logic [4:0] shared_io_out,
    input wire logic [4:0] shared_io_oe_n,
    // Switch levels and drive enables set by the bench
    input wire logic [4:0] sw_level,
    input wire logic [4:0] sw_drive,
    // Resolved pin levels
    output logic [4:0] pin_level
);
    logic [4:0] last_r;
    // Known start so a floating pin never sticks at unknown
    initial begin
        last_r = 5'h00;
    end
    // Undriven pins show a changing pattern, not a held value
    always @(posedge sys_clk) begin
        last_r <= pin_level;
    end
    // Wire resolution, contention shows as unknown
    always_comb begin
        for (int i = 0; i < 5; i++) begin
            if (!shared_io_oe_n[i] && sw_drive[i]) begin
                pin_level[i] = 1'bx;
            end else if (!shared_io_oe_n[i]) begin
                pin_level[i] = shared_io_out[i];
            end else if (sw_drive[i]) begin
                pin_level[i] = sw_level[i];
            end else begin
                pin_level[i] = ~last_r[i];
            end
        end
    end
endmodule
`default_nettype wire

// ---- testbench/tb_multifunction_io_pin_select.sv ----
// Self-checking bench for the shared pin function selector
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_errors++; $display("wrong value at %0t: got %h expected %h", $time, a, b); end end
module tb_multifunction_io_pin_select;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic [4:0] pin, out, oe_n, sw_level = 5'h1f, sw_drive = 5'h00;
    logic [9:0] fn_sel = 10'h000;
    logic [4:0] gp_dir = 5'h00, gp_data = 5'h00, gp_in, trig;
    mfps_pkg::mfps_xmode_t ext_mode = mfps_pkg::MFPS_XM_OFF;
    logic hand = 1'b0, sp_sel = 1'b0, sp_low = 1'b0, hit0 = 1'b0, hit1 = 1'b0;
    logic err = 1'b0, sp_req = 1'b0;
    logic [7:0] sp_width = 8'h01;
    mfps_pkg::mfps_prof_t prof = '0;
    mfps_pkg::mfps_drv_t drv;
    int n_errors = 0, cmp_count = 0;
    logic [7:0] n_pp = 8'h00, n_pn = 8'h00, n_sp = 8'h00, b_pp, b_pn, b_sp;
    // Clock, 25 ns period
    initial begin
        forever #12.5 sys_clk = ~sys_clk;
    end
    mfps_top uut (.sys_clk(sys_clk), .rst(rst), .shared_io_in(pin), .shared_io_out(out),
        .shared_io_oe_n(oe_n), .fn_sel(fn_sel), .gp_dir_out(gp_dir),
        .gp_output_data_reg(gp_data), .ext_mode(ext_mode), .hand_pulse_generator_mode(hand),
        .sync_pulse_sel(sp_sel), .sync_pulse_act_low(sp_low), .sync_pulse_width(sp_width),
        .prof(prof), .compare_hit_0(hit0), .compare_hit_1(hit1), .error_active(err),
        .sync_pulse_req(sp_req), .gp_input_status_reg(gp_in), .sync_trigger(trig),
        .drv_req(drv));
    mfps_pin_model partner (.sys_clk(sys_clk), .shared_io_out(out), .shared_io_oe_n(oe_n),
        .sw_level(sw_level), .sw_drive(sw_drive), .pin_level(pin));
    // Pulse and active-cycle counters
    always @(posedge sys_clk) begin
        n_pp <= n_pp + 8'(drv.pos_rel_pos === 1'b1);
        n_pn <= n_pn + 8'(drv.pos_rel_neg === 1'b1);
        n_sp <= n_sp + 8'(out[2] !== sp_low);
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #2;
    endtask
    task automatic snap();
        b_pp = n_pp;
        b_pn = n_pn;
        b_sp = n_sp;
    endtask
    task automatic test_end(input string name);
        $display("test %s done, mismatches so far %0d", name, n_errors);
    endtask
    task automatic final_report();
        $display("comparisons %0d, mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // Watchdog
    initial begin
        #(25 * 3000);
        n_errors++;
        final_report();
    end
    // Test sequence
    initial begin
        cyc(8);
        `CHK(oe_n, 5'h1f)
        `CHK(out, 5'h00)
        `CHK(drv, 6'h00)
        rst = 1'b0;
        gp_dir = 5'h1f;
        gp_data = 5'h15;
        cyc(1);
        `CHK(out, 5'h15)
        `CHK(oe_n, 5'h00)
        test_end("gpio_out");
        gp_dir = 5'h00;
        gp_data = 5'h00;
        cyc(1);
        sw_drive = 5'h1f;
        sw_level = 5'h0a;
        cyc(3);
        `CHK(oe_n, 5'h1f)
        `CHK(gp_in, 5'h0a)
        `CHK(trig, 5'h0a)
        fn_sel = 10'h004;
        cyc(3);
        `CHK(gp_in, 5'h08)
        test_end("gpio_in");
        sw_drive = 5'h00;
        fn_sel = 10'h2aa;
        err = 1'b1;
        prof = 5'h0f;
        cyc(1);
        `CHK(out, 5'h01)
        `CHK(oe_n, 5'h00)
        err = 1'b0;
        for (int k = 0; k < 4; k++) begin
            prof = {1'b1, 4'(1 << k)};
            cyc(1);
            `CHK(out, 5'(2 << k))
        end
        test_end("status");
        prof = 5'h00;
        fn_sel = 10'h3c3;
        hit0 = 1'b1;
        cyc(1);
        `CHK(out, 5'h08)
        `CHK(oe_n, 5'h07)
        hit0 = 1'b0;
        hit1 = 1'b1;
        cyc(1);
        `CHK(out, 5'h10)
        hit1 = 1'b0;
        test_end("compare");
        fn_sel = 10'h020;
        sp_sel = 1'b1;
        sp_width = 8'h03;
        prof = 5'h12;
        for (int p = 0; p < 2; p++) begin
            cyc(2);
            `CHK(out[2], sp_low)
            snap();
            sp_req = 1'b1;
            cyc(1);
            sp_req = 1'b0;
            cyc(8);
            `CHK(8'(n_sp - b_sp), sp_width == 8'h00 ? 8'h01 : sp_width)
            sp_low = 1'b1;
            sp_width = 8'h00;
        end
        prof = 5'h00;
        test_end("sync_pulse");
        fn_sel = 10'h140;
        cyc(1);
        sw_drive = 5'h1f;
        sw_level = 5'h1f;
        ext_mode = mfps_pkg::MFPS_XM_POS;
        cyc(4);
        `CHK(oe_n[4:3], 2'h3)
        for (int s = 3; s < 5; s++) begin
            snap();
            sw_level[s] = 1'b0;
            cyc(6);
            `CHK(8'(n_pp - b_pp), 8'(s == 3))
            `CHK(8'(n_pn - b_pn), 8'(s == 4))
            sw_level[s] = 1'b1;
            cyc(3);
        end
        ext_mode = mfps_pkg::MFPS_XM_CONT;
        sw_level[3] = 1'b0;
        cyc(3);
        `CHK({drv.cont_pos, drv.cont_neg}, 2'h2)
        sw_level[4] = 1'b0;
        cyc(3);
        `CHK({drv.cont_pos, drv.cont_neg}, 2'h3)
        sw_level = 5'h1f;
        cyc(3);
        `CHK({drv.cont_pos, drv.cont_neg}, 2'h0)
        test_end("ext_start");
        ext_mode = mfps_pkg::MFPS_XM_OFF;
        hand = 1'b1;
        for (int h = 0; h < 2; h++) begin
            sw_level[4:3] = h ? 2'h2 : 2'h1;
            cyc(3);
            `CHK(drv.hand_a, 1'(h == 0))
            `CHK(drv.hand_b, 1'(h == 1))
        end
        test_end("hand_encoder");
        final_report();
    end
endmodule
`default_nettype wire
